// >>> logic/spgc_pkg.sv
// Package for the serial pin general-purpose I/O control block.
// Assumes a 32-bit APB register bus and one pclk domain.
package spgc_pkg;

	// Register byte addresses
	localparam logic [11:0] SPGC_TX_PIN_CTL_ADDR = 12'h000;
	localparam logic [11:0] SPGC_RX_PIN_CTL_ADDR = 12'h004;
	localparam int          SPGC_ADDR_W          = 12;

	// Register geometry
	localparam int          SPGC_DATA_W      = 32;
	localparam int          SPGC_CTL_W       = 12;
	localparam int          SPGC_PINS_PER_REG = 3;
	localparam int          SPGC_PIN_COUNT   = 6;
	localparam int          SPGC_FIELD_STRIDE = 4;

	// Field positions inside each four-bit pin group
	localparam int          SPGC_SELECT_POS = 0;
	localparam int          SPGC_DIR_POS    = 1;
	localparam int          SPGC_OUT_POS    = 2;
	localparam int          SPGC_IN_POS     = 3;

	// Absolute field positions, transmit-side register
	localparam int          SPGC_TX_CLOCK_SELECT_BIT = 0;
	localparam int          SPGC_TX_CLOCK_DIR_BIT    = 1;
	localparam int          SPGC_TX_CLOCK_OUT_BIT    = 2;
	localparam int          SPGC_TX_CLOCK_IN_BIT     = 3;
	localparam int          SPGC_TX_DATA_SELECT_BIT  = 4;
	localparam int          SPGC_TX_DATA_DIR_BIT     = 5;
	localparam int          SPGC_TX_DATA_OUT_BIT     = 6;
	localparam int          SPGC_TX_DATA_IN_BIT      = 7;
	localparam int          SPGC_TX_FSYNC_SELECT_BIT = 8;
	localparam int          SPGC_TX_FSYNC_DIR_BIT    = 9;
	localparam int          SPGC_TX_FSYNC_OUT_BIT    = 10;
	localparam int          SPGC_TX_FSYNC_IN_BIT     = 11;

	// Writable bits and reset values
	localparam logic [11:0] SPGC_WRITE_MASK   = 12'h777;
	localparam logic [11:0] SPGC_CTL_RESET    = 12'h000;
	localparam logic [31:0] SPGC_DATA_RESET   = 32'h0000_0000;
	localparam logic [19:0] SPGC_RESERVED_VAL = 20'h0_0000;

endpackage : spgc_pkg

// >>> logic/spgc_top.sv
// Serial pin control: routes six serial-port pins to the serial port or to
// general-purpose I/O, under two APB registers.
// Assumes pins are asynchronous to pclk; serial-port signals share pclk.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module spgc_top (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [spgc_pkg::SPGC_ADDR_W-1:0] paddr,
	input  wire logic [spgc_pkg::SPGC_DATA_W-1:0] pwdata,
	output logic      [spgc_pkg::SPGC_DATA_W-1:0] prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           tx_clock_pin_i,
	output logic                                tx_clock_pin_o,
	output logic                                tx_clock_pin_oe_n,
	input  wire logic                           tx_serial_out_pin_i,
	output logic                                tx_serial_out_pin_o,
	output logic                                tx_serial_out_pin_oe_n,
	input  wire logic                           tx_frame_sync_pin_i,
	output logic                                tx_frame_sync_pin_o,
	output logic                                tx_frame_sync_pin_oe_n,
	input  wire logic                           rx_clock_pin_i,
	output logic                                rx_clock_pin_o,
	output logic                                rx_clock_pin_oe_n,
	input  wire logic                           rx_serial_in_pin_i,
	output logic                                rx_serial_in_pin_o,
	output logic                                rx_serial_in_pin_oe_n,
	input  wire logic                           rx_frame_sync_pin_i,
	output logic                                rx_frame_sync_pin_o,
	output logic                                rx_frame_sync_pin_oe_n,
	input  wire logic [5:0]                     port_pin_out,
	input  wire logic [5:0]                     port_pin_drive,
	output logic      [5:0]                     port_pin_in
);
	import spgc_pkg::*;

	// Rebuild a full register word from stored control and sensed levels
	function automatic logic [31:0] reg_image(
		input logic [11:0] ctl,
		input logic [2:0]  sense
	);
		logic [11:0] img;
		img = ctl & SPGC_WRITE_MASK;
		for (int k = 0; k < SPGC_PINS_PER_REG; k++) begin
			img[k*SPGC_FIELD_STRIDE + SPGC_IN_POS] = sense[k];
		end
		return {SPGC_RESERVED_VAL, img};
	endfunction : reg_image

	// Select, direction and out field of pin k in a control word
	function automatic logic field_of(
		input logic [11:0] ctl,
		input int          k,
		input int          pos
	);
		return ctl[(k % SPGC_PINS_PER_REG)*SPGC_FIELD_STRIDE + pos];
	endfunction : field_of

	logic [11:0] tx_pin_control;
	logic [11:0] rx_pin_control;
	wire  [5:0]  pin_sync;

	// APB decode
	wire         hit_tx      = (paddr == SPGC_TX_PIN_CTL_ADDR);
	wire         hit_rx      = (paddr == SPGC_RX_PIN_CTL_ADDR);
	wire         access      = psel & penable;
	wire         finish      = access & pready;
	wire         wr_tx       = finish & pwrite & hit_tx;
	wire         wr_rx       = finish & pwrite & hit_rx;
	wire         unmapped    = ~(hit_tx | hit_rx);
	wire  [31:0] tx_image    = reg_image(tx_pin_control, pin_sync[2:0]);
	wire  [31:0] rx_image    = reg_image(rx_pin_control, pin_sync[5:3]);
	wire  [31:0] next_prdata = hit_tx ? tx_image : (hit_rx ? rx_image : SPGC_DATA_RESET);
	wire  [11:0] next_tx_ctl = pwdata[11:0] & SPGC_WRITE_MASK;
	wire  [11:0] next_rx_ctl = pwdata[11:0] & SPGC_WRITE_MASK;

	// Sensed pin levels, as seen in the register in bits
	wire         tx_clock_pin_in;
	wire         tx_serial_out_sense;
	wire         tx_frame_sync_in;
	wire         rx_clock_pin_in;
	wire         rx_serial_in_sense;
	wire         rx_frame_sync_in;

	// Index order matches port_pin_out: tx clock, data, fsync, then rx
	assign pin_sync = {rx_frame_sync_in, rx_serial_in_sense, rx_clock_pin_in,
	                   tx_frame_sync_in, tx_serial_out_sense, tx_clock_pin_in};

	// Serial port side of each pin
	wire         tx_clock_port_out    = port_pin_out[0];
	wire         tx_clock_port_drive  = port_pin_drive[0];
	wire         tx_data_port_out     = port_pin_out[1];
	wire         tx_data_port_drive   = port_pin_drive[1];
	wire         tx_fsync_port_out    = port_pin_out[2];
	wire         tx_fsync_port_drive  = port_pin_drive[2];
	wire         rx_clock_port_out    = port_pin_out[3];
	wire         rx_clock_port_drive  = port_pin_drive[3];
	wire         rx_data_port_out     = port_pin_out[4];
	wire         rx_data_port_drive   = port_pin_drive[4];
	wire         rx_fsync_port_out    = port_pin_out[5];
	wire         rx_fsync_port_drive  = port_pin_drive[5];

	// Transmit clock pin fields
	wire         tx_clock_pin_select  = field_of(tx_pin_control, 0, SPGC_SELECT_POS);
	wire         tx_clock_pin_dir     = field_of(tx_pin_control, 0, SPGC_DIR_POS);
	wire         tx_clock_pin_out     = field_of(tx_pin_control, 0, SPGC_OUT_POS);

	// Transmit data pin fields
	wire         tx_serial_out_select = field_of(tx_pin_control, 1, SPGC_SELECT_POS);
	wire         tx_serial_out_dir    = field_of(tx_pin_control, 1, SPGC_DIR_POS);
	wire         tx_serial_out_level  = field_of(tx_pin_control, 1, SPGC_OUT_POS);

	// Transmit frame sync pin fields
	wire         tx_frame_sync_select = field_of(tx_pin_control, 2, SPGC_SELECT_POS);
	wire         tx_frame_sync_dir    = field_of(tx_pin_control, 2, SPGC_DIR_POS);
	wire         tx_frame_sync_out    = field_of(tx_pin_control, 2, SPGC_OUT_POS);

	// Receive clock pin fields
	wire         rx_clock_pin_select  = field_of(rx_pin_control, 0, SPGC_SELECT_POS);
	wire         rx_clock_pin_dir     = field_of(rx_pin_control, 0, SPGC_DIR_POS);
	wire         rx_clock_pin_out     = field_of(rx_pin_control, 0, SPGC_OUT_POS);

	// Receive data pin fields
	wire         rx_serial_in_select  = field_of(rx_pin_control, 1, SPGC_SELECT_POS);
	wire         rx_serial_in_dir     = field_of(rx_pin_control, 1, SPGC_DIR_POS);
	wire         rx_serial_in_level   = field_of(rx_pin_control, 1, SPGC_OUT_POS);

	// Receive frame sync pin fields
	wire         rx_frame_sync_select = field_of(rx_pin_control, 2, SPGC_SELECT_POS);
	wire         rx_frame_sync_dir    = field_of(rx_pin_control, 2, SPGC_DIR_POS);
	wire         rx_frame_sync_out    = field_of(rx_pin_control, 2, SPGC_OUT_POS);

	// One cell per pin; each keeps its own synchroniser and drive flops
	spgc_pin_cell i_tx_clock (
		.pclk       (pclk),
		.presetn    (presetn),
		.select     (tx_clock_pin_select),
		.dir        (tx_clock_pin_dir),
		.level      (tx_clock_pin_out),
		.port_out   (tx_clock_port_out),
		.port_drive (tx_clock_port_drive),
		.pin_i      (tx_clock_pin_i),
		.pin_o      (tx_clock_pin_o),
		.pin_oe_n   (tx_clock_pin_oe_n),
		.sense      (tx_clock_pin_in),
		.port_in    (port_pin_in[0])
	);

	spgc_pin_cell i_tx_data (
		.pclk       (pclk),
		.presetn    (presetn),
		.select     (tx_serial_out_select),
		.dir        (tx_serial_out_dir),
		.level      (tx_serial_out_level),
		.port_out   (tx_data_port_out),
		.port_drive (tx_data_port_drive),
		.pin_i      (tx_serial_out_pin_i),
		.pin_o      (tx_serial_out_pin_o),
		.pin_oe_n   (tx_serial_out_pin_oe_n),
		.sense      (tx_serial_out_sense),
		.port_in    (port_pin_in[1])
	);

	spgc_pin_cell i_tx_fsync (
		.pclk       (pclk),
		.presetn    (presetn),
		.select     (tx_frame_sync_select),
		.dir        (tx_frame_sync_dir),
		.level      (tx_frame_sync_out),
		.port_out   (tx_fsync_port_out),
		.port_drive (tx_fsync_port_drive),
		.pin_i      (tx_frame_sync_pin_i),
		.pin_o      (tx_frame_sync_pin_o),
		.pin_oe_n   (tx_frame_sync_pin_oe_n),
		.sense      (tx_frame_sync_in),
		.port_in    (port_pin_in[2])
	);

	spgc_pin_cell i_rx_clock (
		.pclk       (pclk),
		.presetn    (presetn),
		.select     (rx_clock_pin_select),
		.dir        (rx_clock_pin_dir),
		.level      (rx_clock_pin_out),
		.port_out   (rx_clock_port_out),
		.port_drive (rx_clock_port_drive),
		.pin_i      (rx_clock_pin_i),
		.pin_o      (rx_clock_pin_o),
		.pin_oe_n   (rx_clock_pin_oe_n),
		.sense      (rx_clock_pin_in),
		.port_in    (port_pin_in[3])
	);

	spgc_pin_cell i_rx_data (
		.pclk       (pclk),
		.presetn    (presetn),
		.select     (rx_serial_in_select),
		.dir        (rx_serial_in_dir),
		.level      (rx_serial_in_level),
		.port_out   (rx_data_port_out),
		.port_drive (rx_data_port_drive),
		.pin_i      (rx_serial_in_pin_i),
		.pin_o      (rx_serial_in_pin_o),
		.pin_oe_n   (rx_serial_in_pin_oe_n),
		.sense      (rx_serial_in_sense),
		.port_in    (port_pin_in[4])
	);

	spgc_pin_cell i_rx_fsync (
		.pclk       (pclk),
		.presetn    (presetn),
		.select     (rx_frame_sync_select),
		.dir        (rx_frame_sync_dir),
		.level      (rx_frame_sync_out),
		.port_out   (rx_fsync_port_out),
		.port_drive (rx_fsync_port_drive),
		.pin_i      (rx_frame_sync_pin_i),
		.pin_o      (rx_frame_sync_pin_o),
		.pin_oe_n   (rx_frame_sync_pin_oe_n),
		.sense      (rx_frame_sync_in),
		.port_in    (port_pin_in[5])
	);

	// Only select, direction and out bits are stored; in bits are rebuilt on read
	// Transmit-side control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pin_control <= SPGC_CTL_RESET;
		end else if (wr_tx) begin
			tx_pin_control <= next_tx_ctl;
		end
	end

	// Receive-side control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_pin_control <= SPGC_CTL_RESET;
		end else if (wr_rx) begin
			rx_pin_control <= next_rx_ctl;
		end
	end

	// APB answer: one wait state, then pready with data for one cycle
	// Read data is latched in the wait cycle so it stands with pready
	wire         wait_cycle   = access & ~pready;
	wire         next_pslverr = wait_cycle & unmapped;
	wire  [31:0] next_rd_word = (wait_cycle & ~pwrite) ? next_prdata : SPGC_DATA_RESET;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= wait_cycle;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= next_pslverr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= SPGC_DATA_RESET;
		end else begin
			prdata <= next_rd_word;
		end
	end

endmodule : spgc_top

// Pin cell: synchroniser, routing and registered drive for one pin.
// Assumes pin_i is asynchronous to pclk; port_out and port_drive are on pclk.
module spgc_pin_cell (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic select,
	input  wire logic dir,
	input  wire logic level,
	input  wire logic port_out,
	input  wire logic port_drive,
	input  wire logic pin_i,
	output logic      pin_o,
	output logic      pin_oe_n,
	output logic      sense,
	output logic      port_in
);
	logic        pin_meta;

	// Serial port owns the pin when selected, else the general-purpose fields do
	wire         next_pin_o    = select ? port_out : level;
	wire         next_pin_oe_n = select ? ~port_drive : ~dir;

	// First synchroniser flop; nothing but sense reads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 1'b0;
		end else begin
			pin_meta <= pin_i;
		end
	end

	// Second synchroniser flop, feeds the register in bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense <= 1'b0;
		end else begin
			sense <= pin_meta;
		end
	end

	// Drive level, registered so a register write never glitches the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_o <= 1'b0;
		end else begin
			pin_o <= next_pin_o;
		end
	end

	// Drive enable, active low; reset leaves the pin released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe_n <= 1'b1;
		end else begin
			pin_oe_n <= next_pin_oe_n;
		end
	end

	// Synchronised level handed to the serial port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_in <= 1'b0;
		end else begin
			port_in <= sense;
		end
	end
endmodule : spgc_pin_cell

// >>> tb/spgc_pins.sv
// Pin partner: six external pins, each with an outside level when released.
// Assumes device drive enables are active low.
`timescale 1ns/10ps
module spgc_pins (
	input  wire logic [5:0] pin_o,
	input  wire logic [5:0] pin_oe_n,
	input  wire logic [5:0] ext_lvl,
	output logic      [5:0] pin_lvl
);
	always_comb for (int k = 0; k < 6; k++) pin_lvl[k] = pin_oe_n[k] ? ext_lvl[k] : pin_o[k];
endmodule : spgc_pins

// >>> tb/spgc_top_sva.sv
// Checker for spgc_top, bound to its ports.
// Assumes one pclk domain and presetn active low.
`timescale 1ns/10ps
module spgc_top_sva (
	input wire logic        pclk, presetn, psel, penable, pwrite, pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic        tx_clock_pin_o, tx_clock_pin_oe_n, tx_serial_out_pin_o,
	input wire logic        tx_serial_out_pin_oe_n, tx_frame_sync_pin_oe_n, rx_serial_in_pin_i,
	input wire logic        rx_serial_in_pin_o, rx_serial_in_pin_oe_n, rx_frame_sync_pin_oe_n,
	input wire logic [5:0]  port_pin_out, port_pin_drive, port_pin_in
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [1:0] up;
	wire wr = psel && penable && pready && pwrite;
	wire w0 = wr && paddr == 12'h000;
	wire w4 = wr && paddr == 12'h004;
	always_ff @(posedge pclk or negedge presetn) if (!presetn) up <= 2'h0; else if (up != 2'h3) up <= up + 2'h1;
	property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
	a_ready: assert property (p_ready) else $error("ready pulse");
	property p_txck; w0 && !pwdata[0] |-> ##2 tx_clock_pin_oe_n == !$past(pwdata[1], 2)
		&& (tx_clock_pin_oe_n || tx_clock_pin_o == $past(pwdata[2], 2)); endproperty
	a_txck: assert property (p_txck) else $error("tx clock pin");
	property p_rxd; w4 && !pwdata[4] |-> ##2 rx_serial_in_pin_oe_n == !$past(pwdata[5], 2)
		&& (rx_serial_in_pin_oe_n || rx_serial_in_pin_o == $past(pwdata[6], 2)); endproperty
	a_rxd: assert property (p_rxd) else $error("rx data pin");
	property p_txd; w0 && pwdata[4] |-> ##2 tx_serial_out_pin_oe_n == !$past(port_pin_drive[1])
		&& (tx_serial_out_pin_oe_n || tx_serial_out_pin_o == $past(port_pin_out[1])); endproperty
	a_txd: assert property (p_txd) else $error("tx data serial");
	property p_rxfs; w4 && pwdata[8] |-> ##2 rx_frame_sync_pin_oe_n == !$past(port_pin_drive[5]);
	endproperty
	a_rxfs: assert property (p_rxfs) else $error("rx fsync serial");
	property p_txfs; w0 && pwdata[9:8] == 2'h0 |-> ##2 tx_frame_sync_pin_oe_n; endproperty
	a_txfs: assert property (p_txfs) else $error("tx fsync input");
	property p_rsv; pready && !pwrite |-> prdata[31:12] == 20'h0_0000; endproperty
	a_rsv: assert property (p_rsv) else $error("upper bits");
	property p_sync; up == 2'h3 |-> port_pin_in[4] == $past(rx_serial_in_pin_i, 3); endproperty
	a_sync: assert property (p_sync) else $error("rx data sync");
endmodule : spgc_top_sva
bind spgc_top spgc_top_sva i_sva (.*);

// >>> tb/spgc_top_tb.sv
// Testbench for spgc_top: APB master, register model, pin partner.
// Assumes spgc_pkg, spgc_top and spgc_pins compiled first.
`timescale 1ns/10ps
module spgc_top_tb;
	import spgc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = 0, rg [2];
	logic [31:0] pwdata = 0, r, x;
	logic [5:0]  pout = 0, pdrv = 0, ext = 0;
	wire  [31:0] prdata;
	wire  [5:0]  po, poe, pi, ppi;
	wire         pready, pslverr;
	int          n_mismatch = 0, check_count = 0, s;
	spgc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_clock_pin_i(pi[0]), .tx_clock_pin_o(po[0]),
		.tx_clock_pin_oe_n(poe[0]), .tx_serial_out_pin_i(pi[1]), .tx_serial_out_pin_o(po[1]),
		.tx_serial_out_pin_oe_n(poe[1]), .tx_frame_sync_pin_i(pi[2]),
		.tx_frame_sync_pin_o(po[2]), .tx_frame_sync_pin_oe_n(poe[2]), .rx_clock_pin_i(pi[3]),
		.rx_clock_pin_o(po[3]), .rx_clock_pin_oe_n(poe[3]), .rx_serial_in_pin_i(pi[4]),
		.rx_serial_in_pin_o(po[4]), .rx_serial_in_pin_oe_n(poe[4]), .rx_frame_sync_pin_i(pi[5]),
		.rx_frame_sync_pin_o(po[5]), .rx_frame_sync_pin_oe_n(poe[5]), .port_pin_out(pout),
		.port_pin_drive(pdrv), .port_pin_in(ppi));
	spgc_pins i_pins (.pin_o(po), .pin_oe_n(poe), .ext_lvl(ext), .pin_lvl(pi));
	function automatic logic lvl(int k);
		logic [3:0] g;
		g = rg[k / 3] >> (4 * (k % 3));
		return g[0] ? (pdrv[k] ? pout[k] : ext[k]) : (g[1] ? g[2] : ext[k]);
	endfunction : lvl
	function automatic logic [31:0] rdv(int j);
		logic [31:0] v;
		v = {20'h0_0000, rg[j] & SPGC_WRITE_MASK};
		for (int p = 0; p < 3; p++) v[4 * p + 3] = lvl(3 * j + p);
		return v;
	endfunction : rdv
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] apb_ready expected 1 seen %b", pready);
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic pins;
		logic [5:0] eo, el;
		for (int k = 0; k < 6; k++) begin
			x = rg[k / 3] >> (4 * (k % 3));
			eo[k] = x[0] ? !pdrv[k] : !x[1];
			el[k] = lvl(k);
		end
		chk("pin_oe_n", eo, poe);
		chk("pin_level", el, pi);
		chk("port_pin_in", el, ppi);
	endtask : pins
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	initial forever #5 pclk = ~pclk;
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		rg[0] = 0;
		rg[1] = 0;
		x = $urandom(32'h3ce2_0339);
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, 12'h000, 0);
		chk("tx_reset", rdv(0), r);
		apb(0, 12'h004, 0);
		chk("rx_reset", rdv(1), r);
		$display("reset test done");
		for (int i = 0; i < 60; i++) begin
			x = $urandom;
			pout <= x[5:0];
			pdrv <= x[11:6];
			ext <= x[17:12];
			s = x[18];
			apb(1, s ? 12'h004 : 12'h000, $urandom);
			rg[s] = pwdata[11:0] & SPGC_WRITE_MASK;
			repeat (5) @(posedge pclk);
			pins();
			apb(0, s ? 12'h004 : 12'h000, 0);
			chk("reg_read", rdv(s), r);
		end
		$display("random test done");
		apb(1, 12'h008, 32'hffff_ffff);
		chk("slverr", 1, e);
		chk("unmapped_rdata", 0, r);
		apb(0, 12'h000, 0);
		chk("after_unmapped", rdv(0), r);
		$display("unmapped test done");
		report_and_stop();
	end
endmodule : spgc_top_tb
